// ### dv/ibm_frame_status_sva.sv
// ports of the status block, watched from outside
module ibm_frame_status_sva
(
    // clock and reset
    input wire logic clock, rstn,
    // register bus handshakes
    input wire logic awready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [31:0] rdata,
    // frame link and engine handshakes
    input wire logic rxLast, execStart, execDone, respStart
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // executor launched, then reports completion
    sequence execRun;
        execStart ##[1:60] execDone;
    endsequence
    chk_exec_src:
        assert property (execStart |-> $past(rxLast) || $past(rxLast, 2))
        else $error("exec start without a frame end");
    chk_exec_pulse:
        assert property (execStart |=> !execStart)
        else $error("exec start longer than one cycle");
    chk_resp_after:
        assert property (execRun |-> ##[0:2] respStart)
        else $error("no response after execution");
    chk_resp_pulse:
        assert property (respStart |=> !respStart)
        else $error("response start longer than one cycle");
    chk_b_hold:
        assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    chk_aw_refuse:
        assert property (bvalid |-> !awready)
        else $error("write address taken during response");
    chk_r_hold:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");
    chk_ar_answer:
        assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
endmodule

// ### dv/ibm_host_model.sv
// remote host: sends frames, plus executor and transmitter answers
module ibm_host_model
(
    // clock
    input wire logic clock,
    // frame byte stream
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxLast,
    // engine handshakes
    input wire logic execStart,
    output logic execDone,
    input wire logic respStart,
    output logic respSent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frm [0:511]; // frame image, filled by the bench
    int lag = 2; // answer delay, raised to test slow replies
    int ex = 0;
    int rs = 0;
    initial
    begin
        rxValid = 1'b0;
        rxData = 8'hA5;
        rxLast = 1'b0;
        execDone = 1'b0;
        respSent = 1'b0;
    end
    task automatic send(input int len);
        for (int i = 0; i < len; i++)
        begin
            @(posedge clock);
            rxValid <= 1'b1;
            rxData <= frm[i];
            rxLast <= (i == len - 1);
        end
        @(posedge clock);
        rxValid <= 1'b0;
        rxLast <= 1'b0;
        // released line shows no stale byte
        rxData <= ~frm[len - 1];
    endtask
    // one-cycle done pulses, lag cycles after each start
    always @(posedge clock)
    begin
        execDone <= (ex == 1);
        respSent <= (rs == 1);
        ex <= execStart ? lag : (ex > 0 ? ex - 1 : 0);
        rs <= respStart ? lag : (rs > 0 ? rs - 1 : 0);
    end
endmodule

// ### dv/test_ibm_frame_status.sv
module test_ibm_frame_status
    import ibm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic rxValid, rxLast, execStart, execDone, respStart, respSent, irq;
    logic [7:0] rxData;
    int errors = 0, checked = 0, nresp = 0;
    always #4 clock = ~clock;
    // response starts seen, to spot an extra one
    always @(posedge clock) if (respStart) nresp <= nresp + 1;
    ibm_frame_status i_dut (.clock, .rstn, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .rxValid, .rxData, .rxLast,
        .execStart, .execDone, .respStart, .respSent, .irq);
    ibm_host_model i_host (.clock, .rxValid, .rxData, .rxLast, .execStart,
        .execDone, .respStart, .respSent);
    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // write; aw and w may be taken on different edges
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er, input string m);
        @(posedge clock);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= d;
        fork
            begin do @(posedge clock); while (!awready); awvalid <= 0; end
            begin do @(posedge clock); while (!wready); wvalid <= 0; end
        join
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er), m);
    endtask
    // read and compare data and answer code
    task automatic st(input logic [11:0] a, input logic [31:0] e,
        input logic [1:0] er, input string m);
        @(posedge clock);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, e, m);
        chk(32'(rresp), 32'(er), m);
    endtask
    // build a frame from the switch address, send it, check status
    task automatic frame(input logic [15:0] fmt, code, input logic [7:0] cmd,
        input int len, input logic bad, input logic [31:0] e, input string m);
        for (int i = 0; i < 512; i++) i_host.frm[i] = 8'h00;
        for (int i = 0; i < 6; i++)
            i_host.frm[i] = IBM_MAC_RST[47 - 8 * i -: 8];
        {i_host.frm[12], i_host.frm[13]} = IBM_HDR_TYPE_RST;
        {i_host.frm[14], i_host.frm[15], i_host.frm[16]} = {fmt, code[15:8]};
        {i_host.frm[17], i_host.frm[18]} = {code[7:0], cmd};
        i_host.frm[5] ^= {8{bad}};
        i_host.send(len);
        repeat (40) @(posedge clock);
        st(IBM_STAT_OFS, e, IBM_RESP_OKAY, m);
    endtask
    task automatic t_regs();
        st(IBM_STAT_OFS, 32'h0000_0000, IBM_RESP_OKAY, "status");
        st(IBM_CTRL_OFS, 32'h0000_40FE, IBM_RESP_OKAY, "ctrl");
        st(IBM_MAC_LO_OFS, 32'hA1FF_FF00, IBM_RESP_OKAY, "mac");
        st(12'h200, 32'h0000_0000, IBM_RESP_SLVERR, "unmapped");
        wr(IBM_STAT_OFS, 32'hFFFF_FFFF, IBM_RESP_SLVERR, "ro");
        wr(IBM_CTRL_OFS, 32'h2000_40FE, IBM_RESP_OKAY, "rst");
        st(IBM_CTRL_OFS, 32'h0000_40FE, IBM_RESP_OKAY, "sc");
        $display("regs done");
    endtask
    task automatic t_good();
        frame(IBM_ACCESS_FMT, 1, 1, 64, 0, 32'hE000_0000, "good");
        i_host.lag = 9;
        frame(IBM_ACCESS_FMT, 2, 6, 320, 0, 32'hE000_0000, "max");
        $display("good done");
    endtask
    task automatic t_err();
        int n;
        frame(16'h9801, 1, 1, 64, 0, 32'hC000_2000, "fmt");
        frame(IBM_ACCESS_FMT, 3, 1, 64, 0, 32'hC000_1000, "code");
        frame(IBM_ACCESS_FMT, 1, 7, 64, 0, 32'hC000_0812, "cmd");
        n = nresp;
        frame(IBM_ACCESS_FMT, 1, 1, 321, 0, 32'h8000_0400, "over");
        chk(32'(nresp), 32'(n), "resp");
        wr(IBM_CTRL_OFS, 32'h4000_40FE, IBM_RESP_OKAY, "chk on");
        frame(IBM_ACCESS_FMT, 1, 1, 64, 1, 32'h8000_4000, "mac");
        wr(IBM_CTRL_OFS, 32'h0000_40FE, IBM_RESP_OKAY, "chk off");
        frame(IBM_ACCESS_FMT, 1, 1, 64, 1, 32'hE000_0000, "off");
        $display("errors done");
    endtask
    task automatic t_irq();
        chk(32'(irq), 32'h0000_0000, "masked");
        wr(IBM_IRQ_MASK_OFS, 32'h0000_2000, IBM_RESP_OKAY, "mask");
        chk(32'(irq), 32'h0000_0001, "irq");
        wr(IBM_IRQ_STAT_OFS, 32'h0000_2000, IBM_RESP_OKAY, "w1c");
        chk(32'(irq), 32'h0000_0000, "cleared");
        $display("irq done");
    endtask
    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs();
        t_good();
        t_err();
        t_irq();
        results();
    end
    // hang guard, far beyond the run length
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        results();
    end
endmodule
bind ibm_frame_status ibm_frame_status_sva i_sva (.clock, .rstn, .awready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .rxLast,
    .execStart, .execDone, .respStart);

// ### include/ibm_pkg.sv
package ibm_pkg;

    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] IBM_CTRL_OFS = 12'h104;
    localparam logic [11:0] IBM_STAT_OFS = 12'h110;
    localparam logic [11:0] IBM_IRQ_STAT_OFS = 12'h114;
    localparam logic [11:0] IBM_IRQ_MASK_OFS = 12'h118;
    localparam logic [11:0] IBM_MAC_HI_OFS = 12'h140;
    localparam logic [11:0] IBM_MAC_LO_OFS = 12'h144;

    // ************************************************************
    // field positions
    // ************************************************************
    // control word
    localparam int IBM_CTRL_DCHK_BIT = 30;
    localparam int IBM_CTRL_RST_BIT = 29;
    // status word, also the layout of irq status and mask
    localparam int IBM_ST_GOOD_BIT = 31;
    localparam int IBM_ST_RESP_BIT = 30;
    localparam int IBM_ST_EXEC_BIT = 29;
    localparam int IBM_ST_MAC_BIT = 14;
    localparam int IBM_ST_FMT_BIT = 13;
    localparam int IBM_ST_CODE_BIT = 12;
    localparam int IBM_ST_CMD_BIT = 11;
    localparam int IBM_ST_OVER_BIT = 10;
    localparam int IBM_ST_LOC_W = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] IBM_HDR_TYPE_RST = 16'h40FE;
    localparam logic [47:0] IBM_MAC_RST = 48'h0010_A1FF_FF00;
    localparam logic [31:0] IBM_IRQ_MASK_RST = 32'h0000_0000;

    // ************************************************************
    // frame layout and checks
    // ************************************************************
    localparam logic [8:0] IBM_OFS_HDR_HI = 9'h00C;
    localparam logic [8:0] IBM_OFS_HDR_LO = 9'h00D;
    localparam logic [8:0] IBM_OFS_FMT_HI = 9'h00E;
    localparam logic [8:0] IBM_OFS_FMT_LO = 9'h00F;
    localparam logic [8:0] IBM_OFS_CODE_HI = 9'h010;
    localparam logic [8:0] IBM_OFS_CODE_LO = 9'h011;
    localparam logic [8:0] IBM_OFS_CMD0 = 9'h012;
    localparam logic [8:0] IBM_MAC_BYTES = 9'h006;
    localparam logic [15:0] IBM_ACCESS_FMT = 16'h9800;
    localparam logic [15:0] IBM_ACCESS_CODE_A = 16'h0001;
    localparam logic [15:0] IBM_ACCESS_CODE_B = 16'h0002;
    // whole frame incl. 8 zero pad bytes and 4-byte fcs
    localparam logic [8:0] IBM_FRAME_MAX = 9'h140;
    localparam logic [7:0] IBM_CMD_MAX_DEF = 8'h06;

    // ************************************************************
    // bus answers
    // ************************************************************
    localparam logic [1:0] IBM_RESP_OKAY = 2'h0;
    localparam logic [1:0] IBM_RESP_SLVERR = 2'h2;

    // engine states
    typedef enum logic [2:0] {
        IBM_IDLE,
        IBM_RECV,
        IBM_SKIP,
        IBM_EXEC,
        IBM_RESP
    } ibm_state_t;

endpackage

// ### verilog/ibm_frame_status.sv
// What this block does
// - good frame sets good-packet flag
// - sent response sets response-done flag
// - all commands executed sets execution-done flag
// - matching header tag clears done and errors
// - destination MAC mismatch raises address error
// - address error only while checking enabled
// - access format not 0x9800 raises error
// - access codes 1 and 2 only
// - unknown command code raises command error
// - frame over 320 bytes raises oversize
// - length counts zero pad and FCS
// - no response for oversized frame
// - command error reports seven-bit location
// - address checking discards mismatching frames
// - engine reset returns machine, self-clears
// - programmable header type, default 0x40FE
//
// The AXI4-Lite interface to the registers was decided locally.
module ibm_frame_status
    import ibm_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic [7:0] CMD_MAX = IBM_CMD_MAX_DEF
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // received management-port byte stream
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    // command executor handshake
    output logic execStart,
    input wire logic execDone,
    // response transmitter handshake
    output logic respStart,
    input wire logic respSent,
    // interrupt
    output logic irq
);

    // ************************************************************
    // reset synchroniser
    // ************************************************************
    logic [1:0] rstSync_q; // two-stage release
    logic rstSn; // synchronised active-low reset

    // async assert, clocked release
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rstSync_q <= 2'b00;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstSn = rstSync_q[1];

    // ************************************************************
    // register file state
    // ************************************************************
    logic dchkEn_q; // destination check enable
    logic [15:0] hdrType_q; // management header type
    logic [47:0] macAddr_q; // switch MAC address
    logic [31:0] irqStat_q; // sticky interrupt causes
    logic [31:0] irqMask_q; // interrupt enables
    logic engRst; // one-cycle engine reset pulse

    // status flags
    logic goodFlag_q;
    logic respFlag_q;
    logic execFlag_q;
    logic macErr_q;
    logic fmtErr_q;
    logic codeErr_q;
    logic cmdErr_q;
    logic overErr_q;
    logic [IBM_ST_LOC_W-1:0] errLoc_q; // bad command position
    logic [31:0] statusWord; // assembled status

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic awHeld_q; // address captured
    logic wHeld_q; // data captured
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite; // both halves present
    logic [31:0] wrMask; // byte lanes as bits

    // either half may arrive first; each is held until the pair writes
    assign awready = !awHeld_q && !bvalid;
    assign wready = !wHeld_q && !bvalid;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;

    // capture address and data halves
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            else if (doWrite)
                awHeld_q <= 1'b0;
            if (wvalid && wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            else if (doWrite)
                wHeld_q <= 1'b0;
        end
    end

    // strobes widened to a bit mask
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wrMask[i*8 +: 8] = {8{wStrb_q[i]}};
    end

    // write response, slverr on unmapped or read-only words
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            bvalid <= 1'b0;
            bresp <= IBM_RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid <= 1'b1;
            case (awAddr_q[11:0])
                IBM_CTRL_OFS, IBM_IRQ_STAT_OFS, IBM_IRQ_MASK_OFS,
                IBM_MAC_HI_OFS, IBM_MAC_LO_OFS:
                    bresp <= IBM_RESP_OKAY;
                default:
                    bresp <= IBM_RESP_SLVERR;
            endcase
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // writable configuration registers
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            dchkEn_q <= 1'b0;
            hdrType_q <= IBM_HDR_TYPE_RST;
            macAddr_q <= IBM_MAC_RST;
            irqMask_q <= IBM_IRQ_MASK_RST;
        end
        else if (doWrite)
        begin
            case (awAddr_q[11:0])
                IBM_CTRL_OFS:
                begin
                    if (wStrb_q[3])
                        dchkEn_q <= wData_q[IBM_CTRL_DCHK_BIT];
                    hdrType_q <= (hdrType_q & ~wrMask[15:0])
                        | (wData_q[15:0] & wrMask[15:0]);
                end
                IBM_IRQ_MASK_OFS:
                    irqMask_q <= (irqMask_q & ~wrMask) | (wData_q & wrMask);
                IBM_MAC_HI_OFS:
                    macAddr_q[47:32] <= (macAddr_q[47:32] & ~wrMask[15:0])
                        | (wData_q[15:0] & wrMask[15:0]);
                IBM_MAC_LO_OFS:
                    macAddr_q[31:0] <= (macAddr_q[31:0] & ~wrMask)
                        | (wData_q & wrMask);
                default:
                begin
                end
            endcase
        end
    end

    assign engRst = doWrite && (awAddr_q[11:0] == IBM_CTRL_OFS)
        && wStrb_q[3] && wData_q[IBM_CTRL_RST_BIT];

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    // one read at a time; data is registered, so reads never touch flags
    assign arready = !rvalid;

    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= IBM_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= IBM_RESP_OKAY;
            case (araddr[11:0])
                // reset bit always reads back as zero
                IBM_CTRL_OFS:
                    rdata <= {1'b0, dchkEn_q, 14'h0000, hdrType_q};
                IBM_STAT_OFS:
                    rdata <= statusWord;
                IBM_IRQ_STAT_OFS:
                    rdata <= irqStat_q;
                IBM_IRQ_MASK_OFS:
                    rdata <= irqMask_q;
                IBM_MAC_HI_OFS:
                    rdata <= {16'h0000, macAddr_q[47:32]};
                IBM_MAC_LO_OFS:
                    rdata <= macAddr_q[31:0];
                default:
                begin
                    rdata <= '0;
                    rresp <= IBM_RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // ************************************************************
    // frame byte counter
    // ************************************************************
    logic [8:0] byteCnt_q; // index of current byte, saturating

    // follows the link regardless of engine state, so frames stay aligned
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
            byteCnt_q <= '0;
        else if (rxValid && rxLast)
            byteCnt_q <= '0;
        else if (rxValid && byteCnt_q != 9'h1FF)
            byteCnt_q <= byteCnt_q + 9'h001;
    end

    // ************************************************************
    // frame parser
    // ************************************************************
    ibm_state_t state_q;
    logic parse; // byte belongs to a frame under check
    logic [7:0] hiByte_q; // first byte of a 16-bit field
    logic macMiss_q; // destination differs so far
    logic cmdEnd_q; // terminating zero command seen
    logic frameBad_q; // some error seen this frame
    logic tagHit; // header type byte pair matches
    logic macByteMiss; // this address byte differs
    logic fmtBad;
    logic codeBad;
    logic cmdSlot; // byte is a command code
    logic cmdBad;
    logic overHit;
    logic macBad; // mismatch while checking on

    assign parse = rxValid && (state_q == IBM_RECV
        || (state_q == IBM_IDLE && byteCnt_q == 9'h000));
    assign macByteMiss = rxData
        != macAddr_q[8'(47 - 8*int'(byteCnt_q)) -: 8];
    assign tagHit = parse && byteCnt_q == IBM_OFS_HDR_LO
        && {hiByte_q, rxData} == hdrType_q;
    assign macBad = tagHit && dchkEn_q && macMiss_q;
    assign fmtBad = parse && byteCnt_q == IBM_OFS_FMT_LO
        && {hiByte_q, rxData} != IBM_ACCESS_FMT;
    assign codeBad = parse && byteCnt_q == IBM_OFS_CODE_LO
        && {hiByte_q, rxData} != IBM_ACCESS_CODE_A
        && {hiByte_q, rxData} != IBM_ACCESS_CODE_B;
    // commands sit every fourth byte from the first command slot
    assign cmdSlot = parse && !cmdEnd_q && byteCnt_q >= IBM_OFS_CMD0
        && byteCnt_q[1:0] == IBM_OFS_CMD0[1:0];
    assign cmdBad = cmdSlot && rxData != 8'h00 && rxData > CMD_MAX;
    // count includes zero pad and fcs
    assign overHit = parse && byteCnt_q >= IBM_FRAME_MAX;

    // per-frame bookkeeping
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            hiByte_q <= '0;
            macMiss_q <= 1'b0;
            cmdEnd_q <= 1'b0;
            frameBad_q <= 1'b0;
        end
        else if (parse)
        begin
            hiByte_q <= rxData;
            if (byteCnt_q == 9'h000)
                macMiss_q <= macByteMiss;
            else if (byteCnt_q < IBM_MAC_BYTES && macByteMiss)
                macMiss_q <= 1'b1;
            if (byteCnt_q == 9'h000)
                cmdEnd_q <= 1'b0;
            else if (cmdSlot && rxData == 8'h00)
                cmdEnd_q <= 1'b1;
            if (byteCnt_q == 9'h000)
                frameBad_q <= 1'b0;
            else if (fmtBad || codeBad || cmdBad || overHit)
                frameBad_q <= 1'b1;
        end
    end

    // ************************************************************
    // engine state machine
    // ************************************************************
    // execution and response are handed to neighbours and awaited
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            state_q <= IBM_IDLE;
            execStart <= 1'b0;
            respStart <= 1'b0;
        end
        else if (engRst)
        begin
            state_q <= IBM_IDLE;
            execStart <= 1'b0;
            respStart <= 1'b0;
        end
        else
        begin
            execStart <= 1'b0;
            respStart <= 1'b0;
            case (state_q)
                IBM_IDLE:
                    if (parse && !rxLast)
                        state_q <= IBM_RECV;
                IBM_RECV:
                    if (parse && byteCnt_q == IBM_OFS_HDR_LO
                        && (!tagHit || macBad))
                        state_q <= rxLast ? IBM_IDLE : IBM_SKIP;
                    else if (parse && rxLast)
                    begin
                        if (overHit || overErr_q)
                            state_q <= IBM_IDLE;
                        else if (frameBad_q || fmtBad || codeBad || cmdBad)
                        begin
                            state_q <= IBM_RESP;
                            respStart <= 1'b1;
                        end
                        else
                        begin
                            state_q <= IBM_EXEC;
                            execStart <= 1'b1;
                        end
                    end
                IBM_SKIP:
                    if (rxValid && rxLast)
                        state_q <= IBM_IDLE;
                IBM_EXEC:
                    if (execDone)
                    begin
                        state_q <= IBM_RESP;
                        respStart <= 1'b1;
                    end
                IBM_RESP:
                    if (respSent)
                        state_q <= IBM_IDLE;
                default:
                    state_q <= IBM_IDLE;
            endcase
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    logic setGood;
    logic setResp;
    logic setExec;

    assign setGood = state_q == IBM_RECV && parse && rxLast
        && !frameBad_q && !fmtBad && !codeBad && !cmdBad && !overHit
        && !overErr_q && byteCnt_q > IBM_OFS_HDR_LO;
    assign setExec = state_q == IBM_EXEC && execDone;
    assign setResp = state_q == IBM_RESP && respSent;

    // sticky flags; the set term wins over the tag clear
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
        begin
            goodFlag_q <= 1'b0;
            respFlag_q <= 1'b0;
            execFlag_q <= 1'b0;
            macErr_q <= 1'b0;
            fmtErr_q <= 1'b0;
            codeErr_q <= 1'b0;
            cmdErr_q <= 1'b0;
            overErr_q <= 1'b0;
            errLoc_q <= '0;
        end
        else
        begin
            goodFlag_q <= goodFlag_q | setGood;
            // matching tag clears done and errors
            respFlag_q <= (respFlag_q && !tagHit) || setResp;
            execFlag_q <= (execFlag_q && !tagHit) || setExec;
            macErr_q <= (macErr_q && !tagHit) || macBad;
            fmtErr_q <= (fmtErr_q && !tagHit) || fmtBad;
            codeErr_q <= (codeErr_q && !tagHit) || codeBad;
            overErr_q <= (overErr_q && !tagHit) || overHit;
            cmdErr_q <= (cmdErr_q && !tagHit) || cmdBad;
            // keep position of first bad command
            if (cmdBad && !cmdErr_q)
                errLoc_q <= byteCnt_q[IBM_ST_LOC_W-1:0];
        end
    end

    // status word, reserved bits zero
    always_comb
    begin
        statusWord = '0;
        statusWord[IBM_ST_GOOD_BIT] = goodFlag_q;
        statusWord[IBM_ST_RESP_BIT] = respFlag_q;
        statusWord[IBM_ST_EXEC_BIT] = execFlag_q;
        statusWord[IBM_ST_MAC_BIT] = macErr_q;
        statusWord[IBM_ST_FMT_BIT] = fmtErr_q;
        statusWord[IBM_ST_CODE_BIT] = codeErr_q;
        statusWord[IBM_ST_CMD_BIT] = cmdErr_q;
        statusWord[IBM_ST_OVER_BIT] = overErr_q;
        statusWord[IBM_ST_LOC_W-1:0] = cmdErr_q ? errLoc_q : '0;
    end

    // ************************************************************
    // interrupt
    // ************************************************************
    logic [31:0] irqSet; // event pulses in status layout
    logic [31:0] irqClr; // write-one-to-clear bits

    always_comb
    begin
        irqSet = '0;
        irqSet[IBM_ST_GOOD_BIT] = setGood;
        irqSet[IBM_ST_RESP_BIT] = setResp;
        irqSet[IBM_ST_EXEC_BIT] = setExec;
        irqSet[IBM_ST_MAC_BIT] = macBad;
        irqSet[IBM_ST_FMT_BIT] = fmtBad;
        irqSet[IBM_ST_CODE_BIT] = codeBad;
        irqSet[IBM_ST_CMD_BIT] = cmdBad;
        irqSet[IBM_ST_OVER_BIT] = overHit;
    end

    assign irqClr = (doWrite && awAddr_q[11:0] == IBM_IRQ_STAT_OFS)
        ? (wData_q & wrMask) : 32'h0000_0000;

    // a new event in the clearing cycle survives
    always_ff @(posedge clock or negedge rstSn)
    begin
        if (!rstSn)
            irqStat_q <= '0;
        else
            irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
    end

    // level output while any enabled cause is pending
    assign irq = |(irqStat_q & irqMask_q);

endmodule
